// ### hdl/oss_pkg.sv
/*
 * Constants and types for the output step sequencer: register map over
 * Avalon-MM, step field layouts, limits, timing and mode encodings.
 * Assumes a single 25 MHz clock and a synchronous active-low reset.
 */
package oss_pkg;

    // Register byte offsets.
    localparam logic [7:0] OSS_REG_CTRL = 8'h00;
    localparam logic [7:0] OSS_REG_STATUS = 8'h04;
    localparam logic [7:0] OSS_REG_SEL = 8'h08;
    localparam logic [7:0] OSS_REG_DCV = 8'h0C;
    localparam logic [7:0] OSS_REG_ACV = 8'h10;
    localparam logic [7:0] OSS_REG_FREQ = 8'h14;
    localparam logic [7:0] OSS_REG_WAVE = 8'h18;
    localparam logic [7:0] OSS_REG_TIME = 8'h1C;
    localparam logic [7:0] OSS_REG_TRANS = 8'h20;
    localparam logic [7:0] OSS_REG_OUT_DCV = 8'h24;
    localparam logic [7:0] OSS_REG_OUT_ACV = 8'h28;
    localparam logic [7:0] OSS_REG_OUT_FREQ = 8'h2C;
    localparam logic [7:0] OSS_REG_NORM_DCV = 8'h30;
    localparam logic [7:0] OSS_REG_NORM_ACV = 8'h34;
    localparam logic [7:0] OSS_REG_NORM_FREQ = 8'h38;

    // Control register command bits (write one to issue) and the output-on level bit.
    localparam int OSS_CMD_START = 0;
    localparam int OSS_CMD_HOLD = 1;
    localparam int OSS_CMD_STOP = 2;
    localparam int OSS_CMD_BRANCH = 3;
    localparam int OSS_CTRL_OUT_ON = 4;

    // Wave and transition field positions.
    localparam int OSS_WAVE_LSB = 0;
    localparam int OSS_PHASE_LSB = 8;
    localparam int OSS_CODE_LSB = 20;
    localparam int OSS_OPDC_LSB = 24;
    localparam int OSS_OPAC_LSB = 26;
    localparam int OSS_OPFR_LSB = 28;
    localparam int OSS_PHEN_BIT = 30;
    localparam int OSS_JUMP_LSB = 0;
    localparam int OSS_BRANCH_LSB = 8;
    localparam int OSS_JCNT_LSB = 16;
    localparam int OSS_END_LSB = 28;

    // Field widths.
    localparam int OSS_CODE_W = 2;
    localparam int OSS_WAVE_W = 5;
    localparam int OSS_PHASE_W = 12;
    localparam int OSS_VOLT_W = 16;
    localparam int OSS_FREQ_W = 16;
    localparam int OSS_TIME_W = 24;
    localparam int OSS_JCNT_W = 10;
    localparam int OSS_STEP_W = 8;

    // Limits in 0.1 V, 0.1 Hz and 0.1 ms units.
    localparam logic [15:0] OSS_DCV_MAX = 16'h1130;
    localparam logic [15:0] OSS_ACV_MAX = 16'h0C1C;
    localparam logic [15:0] OSS_FREQ_MIN = 16'h000A;
    localparam logic [15:0] OSS_FREQ_MAX = 16'h157C;
    localparam logic [23:0] OSS_TIME_MIN = 24'h000001;
    localparam logic [23:0] OSS_TIME_MAX = 24'h98967F;
    localparam logic [9:0] OSS_JCNT_MAX = 10'h3E7;
    localparam logic [7:0] OSS_STEP_FIRST = 8'h01;

    // One step-time unit is 0.1 ms, i.e. 100000 ns; clock period 40 ns.
    localparam int OSS_TICK_NS = 100000;
    localparam int OSS_CLK_NS = 40;
    localparam int OSS_TICK_CYC = OSS_TICK_NS / OSS_CLK_NS;

    // Waveform codes.
    localparam logic [4:0] OSS_SINE_WAVE = 5'h00;
    localparam logic [4:0] OSS_SQUARE_WAVE = 5'h01;
    localparam logic [4:0] OSS_ARBITRARY_WAVE_SLOT = 5'h02;

    // Step operation types.
    typedef enum logic [1:0] {
        OSS_OP_CONST = 2'h0,
        OSS_OP_KEEP = 2'h1,
        OSS_OP_SWEEP = 2'h2
    } oss_op_t;

    // End actions.
    typedef enum logic [1:0] {
        OSS_END_CONTINUE = 2'h0,
        OSS_END_HOLD = 2'h1,
        OSS_END_IDLE = 2'h2
    } oss_end_t;

    // Sequence modes, one-hot.
    typedef enum logic [2:0] {
        OSS_IDLE = 3'h1,
        OSS_RUN = 3'h2,
        OSS_HOLD = 3'h4
    } oss_mode_t;

endpackage : oss_pkg

// ### hdl/oss_sequencer.sv
/*
 * Output step sequencer with a step memory, three operating modes and
 * an Avalon-MM slave. Assumes inputs synchronous to clk, and that the
 * generator reports phase zero with a one-cycle phase_zero pulse.
 */
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
module oss_sequencer
    import oss_pkg::*;
#(
    parameter int STEPS = 256,
    parameter int TICK_CYC = OSS_TICK_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic phase_zero,
    output logic [15:0] out_dc_volt,
    output logic [15:0] out_ac_volt,
    output logic [15:0] out_freq,
    output logic [4:0] out_wave,
    output logic [11:0] out_phase,
    output logic out_enable,
    output logic [1:0] step_code
);

    ////////////////////////////////////////////////////////////////////////
    // Step memory: one entry per step, written through the select register.
    logic [15:0] mem_dcv [STEPS];
    logic [15:0] mem_acv [STEPS];
    logic [15:0] mem_freq [STEPS];
    logic [31:0] mem_wave [STEPS];
    logic [23:0] mem_time [STEPS];
    logic [31:0] mem_trans [STEPS];
    logic [9:0] jcnt [STEPS];

    typedef struct packed {
        oss_mode_t mode;
        logic held_by_cmd;
        logic [7:0] step;
        logic [7:0] sel;
        logic out_on;
        logic [23:0] elapsed;
        logic [15:0] tick;
        logic phase_wait;
        logic [15:0] dcv;
        logic [15:0] acv;
        logic [15:0] freq;
        logic [15:0] dcv0;
        logic [15:0] acv0;
        logic [15:0] freq0;
        logic [4:0] wave;
        logic [11:0] phase;
        logic [1:0] code;
        logic [15:0] n_dcv;
        logic [15:0] n_acv;
        logic [15:0] n_freq;
        logic ack;
        logic [31:0] rdata;
    } oss_state_t;

    oss_state_t s;
    oss_state_t next_s;

    // Linear interpolation between start and target over the step time.
    function automatic logic [15:0] oss_ramp(input logic [15:0] a,
        input logic [15:0] b, input logic [23:0] t, input logic [23:0] n);
        logic signed [41:0] d;
        d = 42'(signed'({1'b0, b})) - 42'(signed'({1'b0, a}));
        d = d * 42'(signed'({1'b0, t}));
        d = d / 42'(signed'({1'b0, (n == 24'h0) ? 24'h1 : n}));
        return 16'(42'(a) + d);
    endfunction : oss_ramp

    // Operation type of a channel taken from the wave word.
    function automatic oss_op_t oss_op(input logic [31:0] w, input int lsb);
        return oss_op_t'(w[lsb +: 2]);
    endfunction : oss_op

    // Output value of one channel according to its operation type.
    function automatic logic [15:0] oss_chan(input oss_op_t op,
        input logic [15:0] prog, input logic [15:0] prev,
        input logic [23:0] t, input logic [23:0] n);
        unique case (op)
            OSS_OP_CONST: return prog;
            OSS_OP_SWEEP: return oss_ramp(prev, prog, t, n);
            default: return prev;
        endcase
    endfunction : oss_chan

    logic [31:0] cur_wave;
    logic [31:0] cur_trans;
    logic [23:0] cur_time;
    logic [7:0] jump_to;
    logic [7:0] branch_to;
    logic [9:0] jprog;
    oss_end_t end_act;
    logic bus_wr;
    logic cmd_ok;
    logic [23:0] ramp_pos;

    assign cur_wave = mem_wave[s.step];
    assign cur_trans = mem_trans[s.step];
    assign cur_time = mem_time[s.step];
    assign jump_to = cur_trans[OSS_JUMP_LSB +: OSS_STEP_W];
    assign branch_to = cur_trans[OSS_BRANCH_LSB +: OSS_STEP_W];
    assign jprog = cur_trans[OSS_JCNT_LSB +: OSS_JCNT_W];
    assign end_act = oss_end_t'(cur_trans[OSS_END_LSB +: 2]);
    assign bus_wr = avs_write && !s.ack;
    // Commands are only honoured while the output is on.
    assign cmd_ok = bus_wr && avs_address == OSS_REG_CTRL
        && s.out_on;
    // The ramp aims at the unit being entered, so the last unit of a sweep
    // lands exactly on the programmed value before the outputs freeze.
    assign ramp_pos = s.elapsed + 24'h000001;

    ////////////////////////////////////////////////////////////////////////
    // Next step after a finished step, with per-step jump counters.
    logic [7:0] seq_next;
    logic jcnt_dec;
    logic jcnt_reload;
    always_comb
    begin
        seq_next = s.step + 8'h01;
        jcnt_dec = 1'b0;
        jcnt_reload = 1'b0;
        if (jump_to != 8'h00)
        begin
            if (jprog == 10'h000)
                seq_next = jump_to;
            else if (jcnt[s.step] != 10'h000)
            begin
                seq_next = jump_to;
                jcnt_dec = 1'b1;
            end
            else
                jcnt_reload = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and bus state update.
    logic step_done;
    logic time_up;
    always_comb
    begin
        next_s = s;
        next_s.ack = 1'b0;
        time_up = s.elapsed >= cur_time;
        // Step ends at its time, or at next phase zero if enabled.
        step_done = s.mode == OSS_RUN && time_up
            && (!cur_wave[OSS_PHEN_BIT] || phase_zero);
        if (s.mode == OSS_RUN)
        begin
            if (s.tick == 16'(TICK_CYC - 1))
            begin
                next_s.tick = 16'h0000;
                if (!time_up)
                    next_s.elapsed = s.elapsed + 24'h000001;
            end
            else
                next_s.tick = s.tick + 16'h0001;
            // Outputs follow the step; frozen once its time is up.
            if (!time_up)
            begin
                next_s.dcv = oss_chan(oss_op(cur_wave, OSS_OPDC_LSB),
                    mem_dcv[s.step], s.dcv0, ramp_pos, cur_time);
                next_s.acv = oss_chan(oss_op(cur_wave, OSS_OPAC_LSB),
                    mem_acv[s.step], s.acv0, ramp_pos, cur_time);
                next_s.freq = oss_chan(oss_op(cur_wave, OSS_OPFR_LSB),
                    mem_freq[s.step], s.freq0, ramp_pos, cur_time);
                next_s.wave = cur_wave[OSS_WAVE_LSB +: OSS_WAVE_W];
                next_s.phase = cur_wave[OSS_PHASE_LSB +: OSS_PHASE_W];
                next_s.code = cur_wave[OSS_CODE_LSB +: OSS_CODE_W];
            end
        end
        if (step_done)
        begin
            next_s.elapsed = 24'h000000;
            next_s.tick = 16'h0000;
            next_s.dcv0 = s.dcv;
            next_s.acv0 = s.acv;
            next_s.freq0 = s.freq;
            // End action wins over the jump target.
            unique case (end_act)
                OSS_END_HOLD:
                begin
                    next_s.mode = OSS_HOLD;
                    next_s.held_by_cmd = 1'b0;
                end
                OSS_END_IDLE:
                begin
                    next_s.mode = OSS_IDLE;
                    next_s.code = 2'h0;
                    next_s.n_dcv = s.dcv;
                    next_s.n_acv = s.acv;
                    next_s.n_freq = s.freq;
                end
                default: next_s.step = seq_next;
            endcase
        end
        // Sequence commands.
        if (cmd_ok && avs_writedata[OSS_CMD_STOP])
        begin
            next_s.mode = OSS_IDLE;
            next_s.code = 2'h0;
            next_s.n_dcv = s.dcv;
            next_s.n_acv = s.acv;
            next_s.n_freq = s.freq;
            if (s.dcv[15] ? (16'(-s.dcv) > OSS_DCV_MAX)
                : (s.dcv > OSS_DCV_MAX))
            begin
                next_s.n_dcv = 16'h0000;
                next_s.out_on = 1'b0;
            end
            if (s.acv > OSS_ACV_MAX)
            begin
                next_s.n_acv = 16'h0000;
                next_s.out_on = 1'b0;
            end
            if (s.freq < OSS_FREQ_MIN || s.freq > OSS_FREQ_MAX)
            begin
                next_s.n_freq = OSS_FREQ_MIN;
                next_s.out_on = 1'b0;
            end
        end
        else if (cmd_ok && avs_writedata[OSS_CMD_HOLD] && s.mode == OSS_RUN)
        begin
            next_s.mode = OSS_HOLD;
            next_s.held_by_cmd = 1'b1;
        end
        else if (cmd_ok && avs_writedata[OSS_CMD_START] && s.mode != OSS_RUN)
        begin
            next_s.mode = OSS_RUN;
            if (s.mode == OSS_IDLE)
            begin
                next_s.step = OSS_STEP_FIRST;
                next_s.elapsed = 24'h000000;
                next_s.tick = 16'h0000;
                next_s.dcv0 = s.n_dcv;
                next_s.acv0 = s.n_acv;
                next_s.freq0 = s.n_freq;
                next_s.dcv = s.n_dcv;
                next_s.acv = s.n_acv;
                next_s.freq = s.n_freq;
            end
            else if (!s.held_by_cmd)
                next_s.step = seq_next;
            // Otherwise resume in place with timers intact.
        end
        else if (cmd_ok && avs_writedata[OSS_CMD_BRANCH]
            && s.mode != OSS_IDLE && branch_to != 8'h00)
        begin
            next_s.step = branch_to;
            next_s.elapsed = 24'h000000;
            next_s.tick = 16'h0000;
            next_s.dcv0 = s.dcv;
            next_s.acv0 = s.acv;
            next_s.freq0 = s.freq;
        end
        // Bus slave: one wait cycle, then acknowledge.
        if ((avs_read || avs_write) && !s.ack)
        begin
            next_s.ack = 1'b1;
            next_s.rdata = 32'h00000000;
            unique case (avs_address)
                OSS_REG_CTRL: next_s.rdata[OSS_CTRL_OUT_ON] = s.out_on;
                OSS_REG_STATUS: next_s.rdata = {13'h0000, s.held_by_cmd,
                    s.code, s.step, 5'h00, s.mode};
                OSS_REG_SEL: next_s.rdata = {24'h000000, s.sel};
                OSS_REG_DCV: next_s.rdata = {16'h0000, mem_dcv[s.sel]};
                OSS_REG_ACV: next_s.rdata = {16'h0000, mem_acv[s.sel]};
                OSS_REG_FREQ: next_s.rdata = {16'h0000, mem_freq[s.sel]};
                OSS_REG_WAVE: next_s.rdata = mem_wave[s.sel];
                OSS_REG_TIME: next_s.rdata = {8'h00, mem_time[s.sel]};
                OSS_REG_TRANS: next_s.rdata = mem_trans[s.sel];
                OSS_REG_OUT_DCV: next_s.rdata = {16'h0000, s.dcv};
                OSS_REG_OUT_ACV: next_s.rdata = {16'h0000, s.acv};
                OSS_REG_OUT_FREQ: next_s.rdata = {16'h0000, s.freq};
                OSS_REG_NORM_DCV: next_s.rdata = {16'h0000, s.n_dcv};
                OSS_REG_NORM_ACV: next_s.rdata = {16'h0000, s.n_acv};
                OSS_REG_NORM_FREQ: next_s.rdata = {16'h0000, s.n_freq};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        if (bus_wr && avs_address == OSS_REG_CTRL)
            next_s.out_on = avs_writedata[OSS_CTRL_OUT_ON]
                && !(cmd_ok && avs_writedata[OSS_CMD_STOP]
                && !next_s.out_on);
        if (bus_wr && avs_address == OSS_REG_SEL)
            next_s.sel = avs_writedata[7:0];
        if (bus_wr && s.mode == OSS_IDLE)
        begin
            if (avs_address == OSS_REG_NORM_DCV)
                next_s.n_dcv = avs_writedata[15:0];
            if (avs_address == OSS_REG_NORM_ACV)
                next_s.n_acv = avs_writedata[15:0];
            if (avs_address == OSS_REG_NORM_FREQ)
                next_s.n_freq = avs_writedata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s <= '0;
            s.mode <= OSS_IDLE;
            s.n_freq <= OSS_FREQ_MIN;
        end
        else if (clk_en)
            s <= next_s;
    end

    // Step memory writes and per-step jump counters.
    logic [23:0] time_w;
    assign time_w = avs_writedata[23:0] < OSS_TIME_MIN ? OSS_TIME_MIN
        : avs_writedata[23:0] > OSS_TIME_MAX ? OSS_TIME_MAX
        : avs_writedata[23:0];
    always_ff @(posedge clk)
    begin
        if (clk_en && bus_wr)
        begin
            unique case (avs_address)
                OSS_REG_DCV: mem_dcv[s.sel] <= avs_writedata[15:0];
                OSS_REG_ACV: mem_acv[s.sel] <= avs_writedata[15:0];
                OSS_REG_FREQ: mem_freq[s.sel] <= avs_writedata[15:0];
                OSS_REG_WAVE: mem_wave[s.sel] <= avs_writedata;
                OSS_REG_TIME: mem_time[s.sel] <= time_w;
                default: ;
            endcase
        end
    end

    // Jump counters: loaded on programming, decremented per jump.
    always_ff @(posedge clk)
    begin
        if (clk_en)
        begin
            if (bus_wr && avs_address == OSS_REG_TRANS)
            begin
                mem_trans[s.sel] <= avs_writedata;
                jcnt[s.sel] <= (avs_writedata[OSS_JCNT_LSB +: OSS_JCNT_W]
                    > OSS_JCNT_MAX) ? OSS_JCNT_MAX
                    : avs_writedata[OSS_JCNT_LSB +: OSS_JCNT_W];
            end
            else if (step_done && end_act == OSS_END_CONTINUE)
            begin
                if (jcnt_dec)
                    jcnt[s.step] <= jcnt[s.step] - 10'h001;
                else if (jcnt_reload)
                    jcnt[s.step] <= jprog;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: run/hold show sequence values, idle shows the normal step DC, AC and frequency; wave and phase always show the sequence values.
    assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
    assign avs_readdata = s.rdata;
    assign out_dc_volt = s.mode == OSS_IDLE ? s.n_dcv : s.dcv;
    assign out_ac_volt = s.mode == OSS_IDLE ? s.n_acv : s.acv;
    assign out_freq = s.mode == OSS_IDLE ? s.n_freq : s.freq;
    assign out_wave = s.wave;
    assign out_phase = s.phase;
    assign out_enable = s.out_on;
    assign step_code = s.code;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    idle_code_low_a: assert property (
        @(posedge clk) disable iff (!resetn)
        s.mode == OSS_IDLE |-> step_code == 2'h0)
        else $error("step code not low in idle");
    start_step_one_a: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && cmd_ok && avs_writedata == 32'h00000011
        && s.mode == OSS_IDLE |=> s.mode == OSS_RUN && s.step == 8'h01)
        else $error("start did not begin at step one");
    hold_cmd_a: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && cmd_ok && avs_writedata == 32'h00000012
        && s.mode == OSS_RUN |=> s.mode == OSS_HOLD && s.held_by_cmd)
        else $error("hold command not taken");
    stop_idle_a: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && cmd_ok && avs_writedata[OSS_CMD_STOP]
        |=> s.mode == OSS_IDLE)
        else $error("stop did not return to idle");
    off_reject_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !s.out_on && s.mode == OSS_IDLE ##1 !s.out_on
        |-> s.mode == OSS_IDLE)
        else $error("command accepted while output off");
    // A branch may move the step while held; the outputs stay put.
    hold_frozen_a: assert property (
        @(posedge clk) disable iff (!resetn)
        s.mode == OSS_HOLD && $past(s.mode) == OSS_HOLD
        |-> $stable(s.dcv) && ($stable(s.step)
        || $past(cmd_ok && avs_writedata[OSS_CMD_BRANCH])))
        else $error("hold mode output changed");
    bus_wait_a: assert property (@(posedge clk) disable iff (!resetn)
        clk_en && avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    end_pri_a: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && step_done && end_act == OSS_END_HOLD && !cmd_ok
        |=> s.mode == OSS_HOLD && $stable(s.step))
        else $error("jump taken before end action");
    phase_wait_a: assert property (
        @(posedge clk) disable iff (!resetn)
        clk_en && s.mode == OSS_RUN && time_up && cur_wave[OSS_PHEN_BIT]
        && !phase_zero && !cmd_ok |=> s.mode == OSS_RUN && $stable(s.step))
        else $error("step ended before phase zero");

endmodule : oss_sequencer

// ### sim/oss_phase_model.sv
/*
 * Generator model for the sequencer: a free-running AC phase source
 * that pulses phase_zero for one cycle at every phase wrap.
 * Assumes the sequencer clock and its synchronous active-low reset.
 */
`timescale 1ns/1ns
module oss_phase_model
#(
    parameter int PERIOD = 7
)
(
    input wire logic clk,
    input wire logic resetn,
    output logic phase_zero
);
    int cnt;

    // Phase counter; the source keeps running whether or not a step waits.
    always_ff @(posedge clk)
    begin
        if (!resetn || cnt == PERIOD - 1)
            cnt <= 0;
        else
            cnt <= cnt + 1;
        phase_zero <= resetn && cnt == PERIOD - 1;
    end
endmodule : oss_phase_model

// ### sim/output_step_sequencer_test.sv
/*
 * Self-checking bench for the output step sequencer over Avalon-MM.
 * Assumes the generator model and a short step tick for speed.
 */
`timescale 1ns/1ns
module output_step_sequencer_test;
    import oss_pkg::*;
    logic clk = 0, resetn = 0, clk_en = 1, avs_read = 0, avs_write = 0;
    logic [7:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, st;
    logic avs_waitrequest, phase_zero, out_enable;
    logic [15:0] out_dc_volt, out_ac_volt, out_freq;
    logic [4:0] out_wave;
    logic [11:0] out_phase;
    logic [1:0] step_code;
    int fails = 0, compares = 0, cycles = 0;
    int twos = 0;
    logic [1:0] last_code = 2'h0;

    oss_sequencer #(.TICK_CYC(4)) dut (.clk, .resetn, .clk_en,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .phase_zero, .out_dc_volt, .out_ac_volt,
        .out_freq, .out_wave, .out_phase, .out_enable, .step_code);
    oss_phase_model phase (.clk, .resetn, .phase_zero);

    ////////////////////////////////////////
    // Clock, and a ceiling on run length so a hang still ends the run.
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test;
        end
    end

    // Counts entries into step code 2, looked at where outputs are settled.
    always @(negedge clk)
    begin
        if (step_code == 2'h2 && last_code != 2'h2)
            twos++;
        last_code = step_code;
    end

    ////////////////////////////////////////
    // One bus transfer: raised just after a rising edge, held through the
    // edge at which waitrequest stands low, and released right after it.
    // Waitrequest and read data are looked at mid-cycle, where they stand
    // settled for the coming edge.
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        logic done;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do
        begin
            @(negedge clk);
            done = (avs_waitrequest === 1'h0);
            st = avs_readdata;
            @(posedge clk);
        end
        while (!done);
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask : bus

    task automatic status;
        bus(OSS_REG_STATUS, 1'h0, 32'h0);
    endtask : status

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Writes one step: values, code, time and transition word.
    task automatic prog(input logic [7:0] s, input logic [15:0] dc,
        input logic [1:0] code, input logic [23:0] t, input logic [31:0] tr);
        bus(OSS_REG_SEL, 1'h1, {24'h0, s});
        bus(OSS_REG_DCV, 1'h1, {16'h0, dc});
        bus(OSS_REG_ACV, 1'h1, 32'h0);
        bus(OSS_REG_FREQ, 1'h1, 32'h64);
        bus(OSS_REG_WAVE, 1'h1, {10'h0, code, 20'h0});
        bus(OSS_REG_TIME, 1'h1, {8'h0, t});
        bus(OSS_REG_TRANS, 1'h1, tr);
    endtask : prog

    ////////////////////////////////////////
    task automatic t_reset;
        @(negedge clk);
        chk("freq", 16'h000A, out_freq);
        chk("code", 2'h0, step_code);
        status;
        chk("mode", OSS_IDLE, st[2:0]);
        $display("reset test done");
    endtask : t_reset

    // Start without output on must be ignored.
    task automatic t_refused;
        prog(8'h01, 16'h0100, 2'h2, 24'h3, 32'h20000000);
        bus(OSS_REG_CTRL, 1'h1, 32'h1);
        status;
        chk("mode", OSS_IDLE, st[2:0]);
        chk("enable", 1'h0, out_enable);
        $display("refused test done");
    endtask : t_refused

    // Step 1 runs its values, then its end action returns to idle.
    task automatic t_run;
        // Output on first: a command in the same write is still refused.
        bus(OSS_REG_CTRL, 1'h1, 32'h10);
        chk("enable", 1'h1, out_enable);
        bus(OSS_REG_CTRL, 1'h1, 32'h11);
        @(negedge clk);
        chk("dc", 16'h0100, out_dc_volt);
        chk("code", 2'h2, step_code);
        chk("ac", 16'h0000, out_ac_volt);
        status;
        chk("mode", OSS_RUN, st[2:0]);
        chk("step", 8'h01, st[15:8]);
        for (int i = 0; i < 50 && st[2:0] !== OSS_IDLE; i++)
            status;
        chk("mode", OSS_IDLE, st[2:0]);
        @(negedge clk);
        chk("code", 2'h0, step_code);
        $display("run test done");
    endtask : t_run

    // Hold, resume, branch to step 3, then stop keeps the live value.
    task automatic t_hold_branch;
        prog(8'h01, 16'h0100, 2'h1, 24'h100, 32'h00000300);
        prog(8'h03, 16'h0200, 2'h3, 24'h100, 32'h00000003);
        bus(OSS_REG_CTRL, 1'h1, 32'h11);
        bus(OSS_REG_CTRL, 1'h1, 32'h12);
        status;
        chk("mode", OSS_HOLD, st[2:0]);
        chk("held", 1'h1, st[18]);
        bus(OSS_REG_CTRL, 1'h1, 32'h11);
        status;
        chk("mode", OSS_RUN, st[2:0]);
        chk("step", 8'h01, st[15:8]);
        bus(OSS_REG_CTRL, 1'h1, 32'h18);
        status;
        chk("step", 8'h03, st[15:8]);
        @(negedge clk);
        chk("dc", 16'h0200, out_dc_volt);
        chk("code", 2'h3, step_code);
        bus(OSS_REG_CTRL, 1'h1, 32'h14);
        status;
        chk("mode", OSS_IDLE, st[2:0]);
        bus(OSS_REG_NORM_DCV, 1'h0, 32'h0);
        chk("norm", 16'h0200, st[15:0]);
        chk("code", 2'h0, step_code);
        $display("hold branch test done");
    endtask : t_hold_branch

    // Loop 1-2 twice more, keep step 3 ending in hold, resume at its jump
    // target 5, which sweeps and waits for phase zero before going idle.
    task automatic t_loop;
        prog(8'h01, 16'h0010, 2'h1, 24'h1, 32'h00000000);
        prog(8'h02, 16'h0020, 2'h2, 24'h1, 32'h00020001);
        prog(8'h03, 16'h0030, 2'h3, 24'h1, 32'h10000005);
        bus(OSS_REG_WAVE, 1'h1, 32'h01312301);
        prog(8'h05, 16'h0080, 2'h0, 24'h2, 32'h20000000);
        bus(OSS_REG_WAVE, 1'h1, 32'h42000002);
        twos = 0;
        bus(OSS_REG_CTRL, 1'h1, 32'h11);
        for (int i = 0; i < 50 && st[2:0] !== OSS_HOLD; i++)
            status;
        chk("mode", OSS_HOLD, st[2:0]);
        chk("held", 1'h0, st[18]);
        chk("step", 8'h03, st[15:8]);
        chk("loops", 3, twos);
        chk("wave", OSS_SQUARE_WAVE, out_wave);
        chk("phase", 12'h123, out_phase);
        bus(OSS_REG_OUT_DCV, 1'h0, 32'h0);
        chk("keep", 16'h0020, st[15:0]);
        bus(OSS_REG_CTRL, 1'h1, 32'h11);
        status;
        chk("step", 8'h05, st[15:8]);
        for (int i = 0; i < 50 && st[2:0] !== OSS_IDLE; i++)
            status;
        chk("mode", OSS_IDLE, st[2:0]);
        bus(OSS_REG_NORM_DCV, 1'h0, 32'h0);
        chk("sweep", 16'h0080, st[15:0]);
        $display("loop test done");
    endtask : t_loop

    ////////////////////////////////////////
    task automatic finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    // Main sequence: reset for five cycles, then each test in turn.
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        t_reset;
        t_refused;
        t_run;
        t_hold_branch;
        t_loop;
        finish_test;
    end
endmodule : output_step_sequencer_test
